// ---- hw/sram_io_pkg.sv ----
package sram_io_pkg;

  // Array geometry
  localparam int ADDR_W = 18;
  localparam int BYTES = 4;
  localparam int BYTE_W = 8;
  localparam int DATA_W = BYTES * BYTE_W;

  // Burst counter
  localparam logic [1:0] BURST_FIRST = 2'h0;
  localparam logic [1:0] BURST_STEP = 2'h1;

  // Scan instruction capture pattern and reset values
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam logic [1:0] IR_RESET = 2'h3;
  localparam logic BYPASS_CAPTURE = 1'h0;

  // One access travelling down the pipeline
  typedef struct packed {
    logic valid;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [1:0] start;
    logic [1:0] count;
    logic [BYTES-1:0] lane_sel_n;
  } op_t;

  localparam op_t OP_IDLE = '0;

  // Data lanes with their parity lanes
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [BYTES-1:0] parity;
  } word_t;

  localparam word_t WORD_ZERO = '0;

  // Test access port states
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001,
    TAP_IDLE = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SHIFT_DR = 16'h0010,
    TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } tap_state_t;

endpackage

// ---- hw/pipelined_sram_io_control.sv ----
// Functional notes
// - Data lanes are driven only while the output-drive pin is low, otherwise they are inputs.
// - Lanes stay off regardless of that pin during write data, after deselect, and when deselected.
// - A clock edge moves the access pipeline and lane registers only while the clock qualifier is low; sleep and scan logic advance regardless.
// - A high qualifier stretches the cycle without deselecting, and the pipeline resumes unchanged.
// - Lane values acting as inputs are captured into an input register on the rising edge.
// - A read presents the word at the address sampled at the edge that started it.
// - Parity lanes follow the data lanes, each written only when its byte select is low.
// - A high burst-order pin selects interleaved order, low selects linear, and it stays static.
// - An unconnected burst-order pin counts as high, giving interleaved order.
// - The scan port changes its serial output on the falling scan clock edge.
// - The scan port samples its data and mode inputs on the rising scan clock edge.
// - A high sleep request enters a low-power state that keeps stored data.
// - Read data leaves the output register at the edge after the one that started the read.
// - Sleep takes two clocks to enter or leave, and pending accesses may be lost.
`timescale 1ns/100ps
`default_nettype none

module pipelined_sram_io_control (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Controller request
  input wire logic i_clock_qualifier_n,
  input wire logic i_select,
  input wire logic i_write_n,
  input wire logic i_load_n,
  input wire logic [sram_io_pkg::ADDR_W-1:0] i_addr,
  input wire logic [sram_io_pkg::BYTES-1:0] i_byte_lane_select_n,
  // Data and parity lanes
  input wire logic i_output_drive_n,
  input wire sram_io_pkg::word_t i_lanes,
  output var sram_io_pkg::word_t o_lanes,
  output logic o_lanes_oe,
  // Straps and sleep
  input wire logic i_burst_order,
  input wire logic i_burst_order_driven,
  input wire logic i_sleep_request,
  output logic o_asleep,
  // Boundary scan
  input wire logic i_tck,
  input wire logic i_tdi,
  input wire logic i_tms,
  output logic o_tdo,
  output logic o_tdo_oe
);

  localparam int DEPTH = 2 ** sram_io_pkg::ADDR_W;

  function automatic logic [1:0] burst_addr(input logic interleaved, input logic [1:0] start,
                                            input logic [1:0] count);
    burst_addr = interleaved ? (start ^ count) : 2'(start + count);
  endfunction

  function automatic sram_io_pkg::word_t merge(input sram_io_pkg::word_t old_w,
                                               input sram_io_pkg::word_t new_w,
                                               input logic [sram_io_pkg::BYTES-1:0] sel_n);
    merge = old_w;
    for (int b = 0; b < sram_io_pkg::BYTES; b++) begin
      if (!sel_n[b]) begin
        merge.data[b*sram_io_pkg::BYTE_W +: sram_io_pkg::BYTE_W] =
          new_w.data[b*sram_io_pkg::BYTE_W +: sram_io_pkg::BYTE_W];
        merge.parity[b] = new_w.parity[b];
      end
    end
  endfunction

  function automatic sram_io_pkg::tap_state_t tap_next(input sram_io_pkg::tap_state_t s,
                                                       input logic tms);
    unique case (s)
      sram_io_pkg::TAP_RESET: tap_next = tms ? sram_io_pkg::TAP_RESET : sram_io_pkg::TAP_IDLE;
      sram_io_pkg::TAP_IDLE: tap_next = tms ? sram_io_pkg::TAP_SEL_DR : sram_io_pkg::TAP_IDLE;
      sram_io_pkg::TAP_SEL_DR: tap_next = tms ? sram_io_pkg::TAP_SEL_IR : sram_io_pkg::TAP_CAP_DR;
      sram_io_pkg::TAP_CAP_DR: tap_next = tms ? sram_io_pkg::TAP_EXIT1_DR : sram_io_pkg::TAP_SHIFT_DR;
      sram_io_pkg::TAP_SHIFT_DR: tap_next = tms ? sram_io_pkg::TAP_EXIT1_DR : sram_io_pkg::TAP_SHIFT_DR;
      sram_io_pkg::TAP_EXIT1_DR: tap_next = tms ? sram_io_pkg::TAP_UPD_DR : sram_io_pkg::TAP_PAUSE_DR;
      sram_io_pkg::TAP_PAUSE_DR: tap_next = tms ? sram_io_pkg::TAP_EXIT2_DR : sram_io_pkg::TAP_PAUSE_DR;
      sram_io_pkg::TAP_EXIT2_DR: tap_next = tms ? sram_io_pkg::TAP_UPD_DR : sram_io_pkg::TAP_SHIFT_DR;
      sram_io_pkg::TAP_UPD_DR: tap_next = tms ? sram_io_pkg::TAP_SEL_DR : sram_io_pkg::TAP_IDLE;
      sram_io_pkg::TAP_SEL_IR: tap_next = tms ? sram_io_pkg::TAP_RESET : sram_io_pkg::TAP_CAP_IR;
      sram_io_pkg::TAP_CAP_IR: tap_next = tms ? sram_io_pkg::TAP_EXIT1_IR : sram_io_pkg::TAP_SHIFT_IR;
      sram_io_pkg::TAP_SHIFT_IR: tap_next = tms ? sram_io_pkg::TAP_EXIT1_IR : sram_io_pkg::TAP_SHIFT_IR;
      sram_io_pkg::TAP_EXIT1_IR: tap_next = tms ? sram_io_pkg::TAP_UPD_IR : sram_io_pkg::TAP_PAUSE_IR;
      sram_io_pkg::TAP_PAUSE_IR: tap_next = tms ? sram_io_pkg::TAP_EXIT2_IR : sram_io_pkg::TAP_PAUSE_IR;
      sram_io_pkg::TAP_EXIT2_IR: tap_next = tms ? sram_io_pkg::TAP_UPD_IR : sram_io_pkg::TAP_SHIFT_IR;
      sram_io_pkg::TAP_UPD_IR: tap_next = tms ? sram_io_pkg::TAP_SEL_DR : sram_io_pkg::TAP_IDLE;
      default: tap_next = sram_io_pkg::TAP_RESET;
    endcase
  endfunction

  // Reset release
  logic rst_meta;
  logic rstn;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rstn <= rst_meta;
    end
  end

  // Sleep synchroniser
  logic sleep_meta;
  logic sleep_sync;

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      sleep_meta <= i_sleep_request;
      sleep_sync <= sleep_meta;
    end
  end

  assign o_asleep = sleep_sync;

  // Access pipeline
  sram_io_pkg::word_t mem [DEPTH];
  sram_io_pkg::op_t s1;
  sram_io_pkg::op_t s2;
  sram_io_pkg::op_t next_s1;
  sram_io_pkg::op_t next_s2;
  sram_io_pkg::word_t out_word;
  sram_io_pkg::word_t next_out_word;
  sram_io_pkg::word_t in_word;
  sram_io_pkg::word_t next_in_word;
  sram_io_pkg::word_t rd_word;
  logic drive;
  logic next_drive;
  logic mode_interleaved;
  logic mem_we;
  logic [1:0] next_count;

  assign mode_interleaved = !i_burst_order_driven || i_burst_order;
  assign rd_word = mem[s1.addr];
  assign mem_we = !i_clock_qualifier_n && !sleep_sync && s2.valid && s2.wr;

  always_comb begin
    next_s1 = s1;
    next_s2 = s2;
    next_out_word = out_word;
    next_in_word = in_word;
    next_drive = drive;
    next_count = 2'(s1.count + sram_io_pkg::BURST_STEP);
    if (!i_clock_qualifier_n) begin
      if (!i_load_n) begin
        next_s1.valid = i_select && !sleep_sync;
        next_s1.wr = !i_write_n;
        next_s1.addr = i_addr;
        next_s1.start = i_addr[1:0];
        next_s1.count = sram_io_pkg::BURST_FIRST;
      end else begin
        next_s1.valid = s1.valid && !sleep_sync;
        next_s1.count = next_count;
        next_s1.addr[1:0] = burst_addr(mode_interleaved, s1.start, next_count);
      end
      next_s1.lane_sel_n = i_byte_lane_select_n;
      next_s2 = s1;
      if (s1.valid && !s1.wr) begin
        next_out_word = rd_word;
        if (s2.valid && s2.wr && s2.addr == s1.addr) begin
          next_out_word = merge(rd_word, i_lanes, s2.lane_sel_n);
        end
      end
      next_drive = s1.valid && !s1.wr && !sleep_sync;
      if (!o_lanes_oe) begin
        next_in_word = i_lanes;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= sram_io_pkg::OP_IDLE;
      s2 <= sram_io_pkg::OP_IDLE;
      out_word <= sram_io_pkg::WORD_ZERO;
      in_word <= sram_io_pkg::WORD_ZERO;
      drive <= 1'b0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      out_word <= next_out_word;
      in_word <= next_in_word;
      drive <= next_drive;
    end
  end

  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[s2.addr] <= merge(mem[s2.addr], i_lanes, s2.lane_sel_n);
    end
  end

  assign o_lanes = out_word;
  assign o_lanes_oe = drive && !i_output_drive_n;

  // Boundary scan
  sram_io_pkg::tap_state_t tap;
  sram_io_pkg::tap_state_t next_tap;
  logic tck_q;
  logic tck_rise;
  logic tck_fall;
  logic [1:0] ir_sh;
  logic [1:0] next_ir_sh;
  logic bypass;
  logic next_bypass;
  logic next_tdo;
  logic next_tdo_oe;

  assign tck_rise = i_tck && !tck_q;
  assign tck_fall = !i_tck && tck_q;

  always_comb begin
    next_tap = tap;
    next_ir_sh = ir_sh;
    next_bypass = bypass;
    next_tdo = o_tdo;
    next_tdo_oe = o_tdo_oe;
    if (tck_rise) begin
      next_tap = tap_next(tap, i_tms);
      unique case (tap)
        sram_io_pkg::TAP_RESET: next_ir_sh = sram_io_pkg::IR_RESET;
        sram_io_pkg::TAP_CAP_IR: next_ir_sh = sram_io_pkg::IR_CAPTURE;
        sram_io_pkg::TAP_SHIFT_IR: next_ir_sh = {i_tdi, ir_sh[1]};
        sram_io_pkg::TAP_CAP_DR: next_bypass = sram_io_pkg::BYPASS_CAPTURE;
        sram_io_pkg::TAP_SHIFT_DR: next_bypass = i_tdi;
        default: next_bypass = bypass;
      endcase
    end
    if (tck_fall) begin
      next_tdo = (tap == sram_io_pkg::TAP_SHIFT_IR) ? ir_sh[0] : bypass;
      next_tdo_oe = tap == sram_io_pkg::TAP_SHIFT_IR || tap == sram_io_pkg::TAP_SHIFT_DR;
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      tap <= sram_io_pkg::TAP_RESET;
      tck_q <= 1'b0;
      ir_sh <= sram_io_pkg::IR_RESET;
      bypass <= sram_io_pkg::BYPASS_CAPTURE;
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else begin
      tap <= next_tap;
      tck_q <= i_tck;
      ir_sh <= next_ir_sh;
      bypass <= next_bypass;
      o_tdo <= next_tdo;
      o_tdo_oe <= next_tdo_oe;
    end
  end

  // Checks
  property p_oe_pin;
    @(posedge i_clk) disable iff (!rstn) o_lanes_oe |-> !i_output_drive_n && s2.valid && !s2.wr;
  endproperty
  a_oe_pin: assert property (p_oe_pin) else $error("lanes driven with drive pin high");

  property p_write_off;
    @(posedge i_clk) disable iff (!rstn) (s2.valid && s2.wr) || !s2.valid |-> !o_lanes_oe;
  endproperty
  a_write_off: assert property (p_write_off) else $error("lanes driven in write or deselect");

  property p_hold;
    @(posedge i_clk) disable iff (!rstn)
      i_clock_qualifier_n |=> $stable(s1) && $stable(s2) && $stable(o_lanes) && $stable(drive);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved with qualifier high");

  property p_capture;
    @(posedge i_clk) disable iff (!rstn)
      rstn && !o_lanes_oe && !i_clock_qualifier_n |=> in_word == $past(i_lanes);
  endproperty
  a_capture: assert property (p_capture) else $error("input lanes not captured");

  property p_read_data;
    @(posedge i_clk) disable iff (!rstn)
      !i_clock_qualifier_n && s1.valid && !s1.wr && !(s2.valid && s2.wr)
      |=> o_lanes == $past(rd_word);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read word mismatch");

  property p_read_latency;
    @(posedge i_clk) disable iff (!rstn)
      (!i_clock_qualifier_n && !i_load_n && i_select && i_write_n && !sleep_sync)
      ##1 (!i_clock_qualifier_n && !sleep_sync) |=> drive;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read not driven next edge");

  property p_tdo_fall;
    @(posedge i_clk) disable iff (!rstn) $changed(o_tdo) |-> $past(tck_fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("scan output moved off falling edge");

  property p_tap_rise;
    @(posedge i_clk) disable iff (!rstn) $changed(tap) |-> $past(tck_rise);
  endproperty
  a_tap_rise: assert property (p_tap_rise) else $error("scan state moved off rising edge");

  property p_sleep_entry;
    @(posedge i_clk) disable iff (!rstn)
      $rose(o_asleep) |-> $past(i_sleep_request, 2) && !o_lanes_oe ##1 !drive;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry timing wrong");

  property p_interleave;
    @(posedge i_clk) disable iff (!rstn)
      !i_burst_order_driven && !i_clock_qualifier_n && i_load_n
      |=> s1.addr[1:0] == ($past(s1.start) ^ $past(next_count));
  endproperty
  a_interleave: assert property (p_interleave) else $error("floating order not interleaved");

endmodule

`default_nettype wire

// ---- verification/sram_ctl_partner.sv ----
`timescale 1ns/100ps
`default_nettype none

module sram_ctl_partner (
  // Clock
  input wire logic i_clk,
  // Controller side
  input wire logic i_drive,
  input wire sram_io_pkg::word_t i_word,
  // Device side
  input wire logic i_dev_oe,
  input wire sram_io_pkg::word_t i_dev_word,
  // Resolved bus
  output var sram_io_pkg::word_t o_bus,
  output logic o_clash
);
  sram_io_pkg::word_t last = '0;

  // Released bus shows a changing pattern, never the old value
  always_comb begin
    if (i_dev_oe) begin
      o_bus = i_dev_word;
    end else if (i_drive) begin
      o_bus = i_word;
    end else begin
      o_bus = ~last;
    end
  end

  always_ff @(posedge i_clk) begin
    last <= o_bus;
  end

  // Both ends driving at once
  assign o_clash = i_dev_oe & i_drive;
endmodule

`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic clk = 0, rstn = 0, qn = 0, sel = 0, wn = 1, ldn = 0, drn = 0;
  logic bo = 1, bod = 1, slp = 0, tck = 0, tdi = 0, tms = 1, cdrv = 0;
  logic oe, asleep, tdo, tdo_oe, clash;
  logic [sram_io_pkg::ADDR_W-1:0] addr = '0, a, ka;
  logic [sram_io_pkg::BYTES-1:0] bsel = '1;
  sram_io_pkg::word_t cword = '0, bus, dout, d;
  sram_io_pkg::word_t w[4];
  sram_io_pkg::word_t mem[logic [sram_io_pkg::ADDR_W-1:0]];
  int err_total = 0, total_checks = 0;

  always #5 clk = ~clk;

  pipelined_sram_io_control dut_u (.i_clk(clk), .i_rstn(rstn), .i_clock_qualifier_n(qn),
    .i_select(sel), .i_write_n(wn), .i_load_n(ldn), .i_addr(addr),
    .i_byte_lane_select_n(bsel), .i_output_drive_n(drn), .i_lanes(bus), .o_lanes(dout),
    .o_lanes_oe(oe), .i_burst_order(bo), .i_burst_order_driven(bod),
    .i_sleep_request(slp), .o_asleep(asleep), .i_tck(tck), .i_tdi(tdi), .i_tms(tms),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe));

  sram_ctl_partner partner_u (.i_clk(clk), .i_drive(cdrv), .i_word(cword), .i_dev_oe(oe),
    .i_dev_word(dout), .o_bus(bus), .o_clash(clash));

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic sram_io_pkg::word_t rnd_word();
    rnd_word = {$urandom, sram_io_pkg::BYTES'($urandom)};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic model_wr(logic [sram_io_pkg::ADDR_W-1:0] ma, sram_io_pkg::word_t md,
                          logic [sram_io_pkg::BYTES-1:0] ms);
    for (int b = 0; b < sram_io_pkg::BYTES; b++) begin
      if (!ms[b]) begin
        mem[ma].data[8*b+:8] = md.data[8*b+:8];
        mem[ma].parity[b] = md.parity[b];
      end
    end
  endtask

  task automatic do_write(logic [sram_io_pkg::ADDR_W-1:0] wa, sram_io_pkg::word_t wd,
                          logic [sram_io_pkg::BYTES-1:0] ws);
    @(negedge clk);
    ldn = 0; sel = 1; wn = 0; addr = wa; bsel = ws;
    @(negedge clk);
    sel = 0;
    @(negedge clk);
    cdrv = 1; cword = wd;
    #1 check("write clash", clash, 0);
    @(negedge clk);
    cdrv = 0;
    if (!slp) model_wr(wa, wd, ws);
  endtask

  task automatic do_read(logic [sram_io_pkg::ADDR_W-1:0] ra, int stall);
    @(negedge clk);
    ldn = 0; sel = 1; wn = 1; addr = ra; drn = 1'($urandom);
    @(negedge clk);
    sel = 0; qn = (stall != 0);
    if (stall != 0) begin
      repeat (stall) @(negedge clk);
      check("stalled oe", oe, 0);
      qn = 0;
    end
    @(negedge clk);
    check("read data", dout, mem[ra]);
    check("read oe", oe, !drn);
  endtask

  task automatic scan_step(logic m, logic di);
    @(negedge clk);
    tms = m; tdi = di;
    repeat (4) @(negedge clk);
    tck = 1;
    repeat (4) @(negedge clk);
    tck = 0;
    repeat (4) @(negedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end

  initial begin
    void'($urandom(32'h7842de8b));
    repeat (3) @(negedge clk);
    rstn = 1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      a = sram_io_pkg::ADDR_W'($urandom); d = rnd_word();
      do_write(a, d, '0);
      d = rnd_word();
      do_write(a, d, sram_io_pkg::BYTES'($urandom));
      do_read(a, $urandom % 4);
    end
    $display("single access test done");
    for (int m = 0; m < 3; m++) begin
      bo = (m == 0); bod = (m != 2);
      a = {(sram_io_pkg::ADDR_W-2)'($urandom), 2'h1};
      for (int k = 0; k < 4; k++) w[k] = rnd_word();
      for (int t = 0; t < 6; t++) begin
        @(negedge clk);
        ldn = (t > 0 && t < 4); sel = (t == 0); wn = 0; addr = a; bsel = '0;
        cdrv = (t >= 2);
        if (t >= 2) cword = w[t-2];
      end
      @(negedge clk);
      cdrv = 0;
      for (int k = 0; k < 4; k++) begin
        ka = {a[sram_io_pkg::ADDR_W-1:2], (bo || !bod) ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
        mem[ka] = w[k];
        do_read(ka, 0);
      end
    end
    $display("burst order test done");
    @(negedge clk);
    slp = 1;
    @(negedge clk);
    check("asleep one edge", asleep, 0);
    @(negedge clk);
    check("asleep two edges", asleep, 1);
    do_write(a, ~mem[a], '0);
    slp = 0;
    repeat (2) @(negedge clk);
    check("awake", asleep, 0);
    repeat (4) @(negedge clk);
    do_read(a, 0);
    $display("sleep test done");
    for (int i = 0; i < 5; i++) scan_step(1, 0);
    scan_step(0, 0);
    scan_step(1, 0);
    scan_step(0, 0);
    scan_step(0, 0);
    check("tdo enable in shift", tdo_oe, 1);
    scan_step(0, 1);
    check("tdo bypass one", tdo, 1);
    scan_step(0, 0);
    check("tdo bypass zero", tdo, 0);
    scan_step(1, 0);
    check("tdo enable off", tdo_oe, 0);
    for (int i = 0; i < 3; i++) scan_step(1, 0);
    scan_step(0, 0);
    scan_step(0, 0);
    check("tdo ir capture low", tdo, sram_io_pkg::IR_CAPTURE[0]);
    scan_step(0, 1);
    check("tdo ir capture high", tdo, sram_io_pkg::IR_CAPTURE[1]);
    scan_step(0, 0);
    check("tdo ir shifted in", tdo, 1);
    $display("scan test done");
    test_done();
  end
endmodule

`default_nettype wire
